// >>> core/dual_group_timer_unit.sv
// Top level of the dual group timer unit with five 16-bit timers.
// Operation
// - Five 16-bit timers in two separate groups
// - First group: timer, gated, counter, encoder modes
// - Timer mode counts prescaled clock, finest 4
// - Counter mode counts input pin events
// - Gated mode counts only during active gate
// - Direction from software or direction pin
// - Encoder mode derives count from A/B
// - Core toggle latch flips on each wrap
// - Core toggle latch clocks auxiliary timers
// - Auxiliary in capture/reload role stops counting
// - Capture role latches core on pin event
// - Reload role loads core on pin/latch edge
// - Opposite latch edge reloads yield continuous PWM
// - Second group two timers, finest 2
// - Second group prescaled or external clock, direction
// - Second toggle latch flips, clocks second aux
// - Second core wrap reloads, clocks compare unit
// - Capture register latches second aux, optionally clears
// - Capture trigger from core input/direction pins
`timescale 1ns/10ps
module dual_group_timer_unit
  import timer_unit_pkg::*;
#(
  parameter int TW = 16
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire grp1_cfg_t core_cfg_i,
  input wire grp1_cfg_t aux_a_cfg_i,
  input wire grp1_cfg_t aux_b_cfg_i,
  input wire grp2_cfg_t second_core_cfg_i,
  input wire grp2_cfg_t second_aux_cfg_i,
  input wire logic [1:0] cap_edge_i,
  input wire logic [1:0] cap_src_i,
  input wire logic cap_clear_en_i,
  input wire logic core_toggle_oe_en_i,
  input wire logic second_toggle_oe_en_i,
  input wire logic [2:0] timer_input_pin_i,
  input wire logic [2:0] direction_input_pin_i,
  input wire logic [1:0] second_input_pin_i,
  input wire logic [1:0] second_dir_pin_i,
  input wire logic capture_input_pin_i,
  input wire logic [4:0] wr_en_i,
  input wire logic [TW-1:0] wr_data_i,
  output logic [TW-1:0] aux_timer_a_o,
  output logic [TW-1:0] core_timer_o,
  output logic [TW-1:0] aux_timer_b_o,
  output logic [TW-1:0] second_aux_timer_o,
  output logic [TW-1:0] second_core_timer_o,
  output logic [TW-1:0] capture_reload_reg_o,
  output logic core_toggle_latch_o,
  output logic second_toggle_latch_o,
  output logic core_toggle_pin_o,
  output logic second_toggle_pin_o,
  output logic compare_clk_o,
  output logic [4:0] wrap_o
);
  `include "timer_unit_defines.svh"
  // ---------------------------------------------------------------
  // First group count logic
  // ---------------------------------------------------------------
  grp1_cfg_t cfg1 [3];
  logic [TW-1:0] cnt1_q [3];
  step_t step1 [3];
  logic [2:0] pre_tick1;
  logic [2:0] in_hit;
  logic [2:0] in_rise;
  logic [2:0] in_fall;
  logic [2:0] dir_rise;
  logic [2:0] dir_fall;
  logic [2:0] trig_hit;
  logic [2:0] wrap1;
  logic core_latch_q;
  logic core_latch_rise;
  logic core_latch_fall;
  logic [2:0] reload_hit;
  logic [2:0] capture_hit;
  assign cfg1[0] = aux_a_cfg_i;
  assign cfg1[1] = core_cfg_i;
  assign cfg1[2] = aux_b_cfg_i;
  // Index 1 is the core timer; 0 and 2 are the auxiliary timers.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_grp1
      logic gate_on;
      logic dn;
      logic cnt_ev;
      logic latch_ev;
      logic enc_ev;
      logic enc_dn;
      logic a_lvl;
      logic b_lvl;
      prescale_tick #(.BASE_DIV(`GRP1_BASE_DIV)) u_pre (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .run_i(cfg1[g].run),
        .sel_i(cfg1[g].prescale),
        .tick_o(pre_tick1[g])
      );
      edge_sense u_in (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .pin_i(timer_input_pin_i[g]),
        .sel_i(cfg1[g].cnt_edge),
        .hit_o(in_hit[g]),
        .rise_o(in_rise[g]),
        .fall_o(in_fall[g])
      );
      edge_sense u_dir (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .pin_i(direction_input_pin_i[g]),
        .sel_i(`EDGE_BOTH),
        .hit_o(),
        .rise_o(dir_rise[g]),
        .fall_o(dir_fall[g])
      );
      // Trigger edge for capture or external reload uses the input pin.
      assign trig_hit[g] = (cfg1[g].trig_edge[0] && in_rise[g]) ||
                           (cfg1[g].trig_edge[1] && in_fall[g]);
      assign gate_on = timer_input_pin_i[g] ^ cfg1[g].gate_active_low;
      // Pin level high selects down when external direction is on.
      assign dn = cfg1[g].ext_dir_en ? direction_input_pin_i[g] : cfg1[g].soft_down;
      // Auxiliary timers may count core latch edges instead of pin events.
      assign latch_ev = (cfg1[g].cnt_edge[0] && core_latch_rise) ||
                        (cfg1[g].cnt_edge[1] && core_latch_fall);
      assign cnt_ev = (g != 1 && cfg1[g].latch_clk) ? latch_ev : in_hit[g];
      // Quadrature: each edge of A or B counts; direction from the other level.
      assign a_lvl = timer_input_pin_i[g];
      assign b_lvl = direction_input_pin_i[g];
      assign enc_ev = in_rise[g] || in_fall[g] || dir_rise[g] || dir_fall[g];
      assign enc_dn = (in_rise[g] || in_fall[g]) ? (a_lvl == b_lvl) : (a_lvl != b_lvl);
      // Mode selection; a timer in capture or reload role does not count.
      always_comb begin
        step1[g] = '{step: 1'b0, down: dn};
        if (cfg1[g].run && cfg1[g].role == `ROLE_NORMAL) begin
          unique case (cfg1[g].mode)
            `MODE_TIMER: step1[g].step = pre_tick1[g];
            `MODE_GATED: step1[g].step = pre_tick1[g] && gate_on;
            `MODE_COUNTER: step1[g].step = cnt_ev;
            `MODE_INCR: begin
              step1[g].step = enc_ev;
              step1[g].down = enc_dn ^ cfg1[g].soft_down;
            end
          endcase
        end
      end
      // Wrap at either end in the direction of travel.
      assign wrap1[g] = step1[g].step &&
        (step1[g].down ? (cnt1_q[g] == `TMR_ZERO) : (cnt1_q[g] == `TMR_ONES));
      assign reload_hit[g] = (g != 1) && cfg1[g].role == `ROLE_RELOAD &&
        (trig_hit[g] ||
         (cfg1[g].cnt_edge[0] && core_latch_rise) ||
         (cfg1[g].cnt_edge[1] && core_latch_fall));
      assign capture_hit[g] = (g != 1) && cfg1[g].role == `ROLE_CAPTURE && trig_hit[g];
    end
  endgenerate
  assign core_latch_rise = wrap1[1] && !core_latch_q;
  assign core_latch_fall = wrap1[1] && core_latch_q;
  // Core timer: software write, reload from either auxiliary, or count.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt1_q[1] <= `TMR_ZERO;
    end else if (ce_i) begin
      if (wr_en_i[1]) begin
        cnt1_q[1] <= wr_data_i;
      end else if (reload_hit[0]) begin
        cnt1_q[1] <= cnt1_q[0];
      end else if (reload_hit[2]) begin
        cnt1_q[1] <= cnt1_q[2];
      end else if (step1[1].step) begin
        cnt1_q[1] <= step1[1].down ? cnt1_q[1] - 16'h0001 : cnt1_q[1] + 16'h0001;
      end
    end
  end
  // Auxiliary timers: write, capture of core, or count.
  generate
    for (g = 0; g < 3; g += 2) begin : g_aux
      always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          cnt1_q[g] <= `TMR_ZERO;
        end else if (ce_i) begin
          if (wr_en_i[g]) begin
            cnt1_q[g] <= wr_data_i;
          end else if (capture_hit[g]) begin
            cnt1_q[g] <= cnt1_q[1];
          end else if (step1[g].step) begin
            cnt1_q[g] <= step1[g].down ? cnt1_q[g] - 16'h0001 : cnt1_q[g] + 16'h0001;
          end
        end
      end
    end
  endgenerate
  // Core toggle latch inverts on each core wrap.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      core_latch_q <= 1'b0;
    end else if (ce_i && wrap1[1]) begin
      core_latch_q <= !core_latch_q;
    end
  end
  // ---------------------------------------------------------------
  // Second group count logic
  // ---------------------------------------------------------------
  grp2_cfg_t cfg2 [2];
  logic [TW-1:0] cnt2_q [2];
  step_t step2 [2];
  logic [1:0] pre_tick2;
  logic [1:0] in2_hit;
  logic [1:0] wrap2;
  logic second_latch_q;
  logic cap_pin_hit;
  logic cap_hit;
  logic cap_rise;
  logic cap_fall;
  logic [TW-1:0] capreg_q;
  logic compare_clk_q;
  assign cfg2[0] = second_aux_cfg_i;
  assign cfg2[1] = second_core_cfg_i;
  generate
    for (g = 0; g < 2; g++) begin : g_grp2
      logic ext_ev;
      prescale_tick #(.BASE_DIV(`GRP2_BASE_DIV)) u_pre (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .run_i(cfg2[g].run),
        .sel_i(cfg2[g].prescale),
        .tick_o(pre_tick2[g])
      );
      edge_sense u_in (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .pin_i(second_input_pin_i[g]),
        .sel_i(cfg2[g].cnt_edge),
        .hit_o(in2_hit[g]),
        .rise_o(),
        .fall_o()
      );
      // Second aux may count second latch changes instead of its pin.
      assign ext_ev = (g == 0 && cfg2[g].latch_clk) ? wrap2[1] : in2_hit[g];
      assign step2[g].step = cfg2[g].run && (cfg2[g].ext_clk ? ext_ev : pre_tick2[g]);
      assign step2[g].down = cfg2[g].ext_dir_en ? second_dir_pin_i[g] : cfg2[g].soft_down;
      assign wrap2[g] = step2[g].step &&
        (step2[g].down ? (cnt2_q[g] == `TMR_ZERO) : (cnt2_q[g] == `TMR_ONES));
    end
  endgenerate
  edge_sense u_cap (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .pin_i(capture_input_pin_i),
    .sel_i(cap_edge_i),
    .hit_o(cap_pin_hit),
    .rise_o(cap_rise),
    .fall_o(cap_fall)
  );
  // Capture trigger source selection.
  always_comb begin
    unique case (cap_src_i)
      `CAPSRC_PIN: cap_hit = cap_pin_hit;
      `CAPSRC_CIN: cap_hit = in_rise[1] || in_fall[1];
      `CAPSRC_CDIR: cap_hit = dir_rise[1] || dir_fall[1];
      `CAPSRC_CBOTH: cap_hit = in_rise[1] || in_fall[1] || dir_rise[1] || dir_fall[1];
    endcase
  end
  // Second aux timer: write, clear after capture, or count.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt2_q[0] <= `TMR_ZERO;
    end else if (ce_i) begin
      if (wr_en_i[3]) begin
        cnt2_q[0] <= wr_data_i;
      end else if (cap_hit && cap_clear_en_i) begin
        cnt2_q[0] <= `TMR_ZERO;
      end else if (step2[0].step) begin
        cnt2_q[0] <= step2[0].down ? cnt2_q[0] - 16'h0001 : cnt2_q[0] + 16'h0001;
      end
    end
  end
  // Second core timer reloads from the capture register on each wrap.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt2_q[1] <= `TMR_ZERO;
    end else if (ce_i) begin
      if (wr_en_i[4]) begin
        cnt2_q[1] <= wr_data_i;
      end else if (wrap2[1]) begin
        cnt2_q[1] <= capreg_q;
      end else if (step2[1].step) begin
        cnt2_q[1] <= step2[1].down ? cnt2_q[1] - 16'h0001 : cnt2_q[1] + 16'h0001;
      end
    end
  end
  // Capture register takes the second aux value on a trigger.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      capreg_q <= `TMR_ZERO;
    end else if (ce_i && cap_hit) begin
      capreg_q <= cnt2_q[0];
    end
  end
  // Second toggle latch and compare unit clock pulse.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      second_latch_q <= 1'b0;
      compare_clk_q <= 1'b0;
    end else if (ce_i) begin
      compare_clk_q <= wrap2[1];
      if (wrap2[1]) begin
        second_latch_q <= !second_latch_q;
      end
    end
  end
  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign aux_timer_a_o = cnt1_q[0];
  assign core_timer_o = cnt1_q[1];
  assign aux_timer_b_o = cnt1_q[2];
  assign second_aux_timer_o = cnt2_q[0];
  assign second_core_timer_o = cnt2_q[1];
  assign capture_reload_reg_o = capreg_q;
  assign core_toggle_latch_o = core_latch_q;
  assign second_toggle_latch_o = second_latch_q;
  assign core_toggle_pin_o = core_toggle_oe_en_i && core_latch_q;
  assign second_toggle_pin_o = second_toggle_oe_en_i && second_latch_q;
  assign compare_clk_o = compare_clk_q;
  assign wrap_o = {wrap2[1], wrap2[0], wrap1[2], wrap1[1], wrap1[0]};
  // Unused cap edge outputs kept for observation by nobody; tie off.
  logic unused_cap;
  assign unused_cap = cap_rise ^ cap_fall;
endmodule

// >>> core/timer_unit_defines.svh
// Constants shared by the dual group timer unit files.
`ifndef TIMER_UNIT_DEFINES_SVH
`define TIMER_UNIT_DEFINES_SVH
`define TMR_W 16
`define TMR_ZERO 16'h0000
`define TMR_ONES 16'hffff
`define GRP1_BASE_DIV 3'h4
`define GRP2_BASE_DIV 3'h2
`define PRE_W 3
`define PRE_CNT_W 11
`define MODE_TIMER 2'h0
`define MODE_GATED 2'h1
`define MODE_COUNTER 2'h2
`define MODE_INCR 2'h3
`define ROLE_NORMAL 2'h0
`define ROLE_CAPTURE 2'h1
`define ROLE_RELOAD 2'h2
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
`define CAPSRC_PIN 2'h0
`define CAPSRC_CIN 2'h1
`define CAPSRC_CDIR 2'h2
`define CAPSRC_CBOTH 2'h3
`endif

// >>> core/timer_unit_pkg.sv
// Types shared by the dual group timer unit files.
package timer_unit_pkg;
  // Per-timer configuration of a first-group timer.
  typedef struct packed {
    logic run;
    logic [1:0] mode;
    logic [2:0] prescale;
    logic soft_down;
    logic ext_dir_en;
    logic gate_active_low;
    logic [1:0] cnt_edge;
    logic [1:0] role;
    logic [1:0] trig_edge;
    logic latch_clk;
  } grp1_cfg_t;
  // Configuration of a second-group timer.
  typedef struct packed {
    logic run;
    logic ext_clk;
    logic [2:0] prescale;
    logic soft_down;
    logic ext_dir_en;
    logic [1:0] cnt_edge;
    logic latch_clk;
  } grp2_cfg_t;
  // Count request from the mode logic to a counter register.
  typedef struct packed {
    logic step;
    logic down;
  } step_t;
endpackage

// >>> core/prescale_tick.sv
// Prescaler producing one tick every base times two to the power of a selection.
`timescale 1ns/10ps
module prescale_tick
  import timer_unit_pkg::*;
#(
  parameter logic [2:0] BASE_DIV = 3'h4
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [2:0] sel_i,
  output logic tick_o
);
  `include "timer_unit_defines.svh"
  logic [`PRE_CNT_W-1:0] cnt_q;
  logic [`PRE_CNT_W-1:0] limit;
  // Period minus one; selection doubles the base interval per step.
  assign limit = (`PRE_CNT_W'(BASE_DIV) << sel_i) - `PRE_CNT_W'(1);
  assign tick_o = run_i && (cnt_q == limit);
  // Free counter cleared on each tick or while stopped.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      if (!run_i || tick_o) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + `PRE_CNT_W'(1);
      end
    end
  end
endmodule

// >>> core/edge_sense.sv
// Edge detector on a synchronous pin with selectable sense.
`timescale 1ns/10ps
module edge_sense (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic pin_i,
  input wire logic [1:0] sel_i,
  output logic hit_o,
  output logic rise_o,
  output logic fall_o
);
  `include "timer_unit_defines.svh"
  logic prev_q;
  assign rise_o = pin_i && !prev_q;
  assign fall_o = !pin_i && prev_q;
  assign hit_o = (sel_i[0] && rise_o) || (sel_i[1] && fall_o);
  // Previous pin level for edge comparison.
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_q <= 1'b0;
    end else if (ce_i) begin
      prev_q <= pin_i;
    end
  end
endmodule

// >>> verification/dual_group_timer_unit_properties.sv
// Checker with the concurrent properties of the dual group timer unit.
`timescale 1ns/10ps
`include "timer_unit_defines.svh"
module dgtu_checker
  import timer_unit_pkg::*;
#(
  parameter int TW = 16
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire grp1_cfg_t aux_a_cfg_i,
  input wire grp2_cfg_t second_core_cfg_i,
  input wire logic core_toggle_oe_en_i,
  input wire logic second_toggle_oe_en_i,
  input wire logic [4:0] wr_en_i,
  input wire logic [TW-1:0] wr_data_i,
  input wire logic [TW-1:0] aux_timer_a_o,
  input wire logic [TW-1:0] core_timer_o,
  input wire logic [TW-1:0] second_core_timer_o,
  input wire logic core_toggle_latch_o,
  input wire logic second_toggle_latch_o,
  input wire logic core_toggle_pin_o,
  input wire logic second_toggle_pin_o,
  input wire logic compare_clk_o,
  input wire logic [4:0] wrap_o
);
  // All checks sample on the rising edge and rest while reset is low.
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_core_latch_flip: assert property (
    wrap_o[1] && ce_i |=> core_toggle_latch_o != $past(core_toggle_latch_o))
    else $error("core toggle latch did not flip on a wrap");
  a_core_latch_hold: assert property (
    !wrap_o[1] |=> $stable(core_toggle_latch_o))
    else $error("core toggle latch moved without a wrap");
  a_second_latch_flip: assert property (
    wrap_o[4] && ce_i |=> second_toggle_latch_o != $past(second_toggle_latch_o))
    else $error("second toggle latch did not flip on a wrap");
  a_core_pin_gate: assert property (
    core_toggle_pin_o == (core_toggle_latch_o && core_toggle_oe_en_i))
    else $error("core toggle pin does not follow its latch");
  a_second_pin_gate: assert property (
    second_toggle_pin_o == (second_toggle_latch_o && second_toggle_oe_en_i))
    else $error("second toggle pin does not follow its latch");
  a_compare_clk_follow: assert property (
    wrap_o[4] && ce_i |=> compare_clk_o)
    else $error("no compare clock pulse after a second core wrap");
  a_compare_clk_cause: assert property (
    compare_clk_o |-> $past(wrap_o[4]))
    else $error("compare clock pulse without a second core wrap");
  a_reload_aux_hold: assert property (
    aux_a_cfg_i.role == `ROLE_RELOAD && !wr_en_i[0] |=> $stable(aux_timer_a_o))
    else $error("auxiliary timer in reload role changed");
  a_core_write_load: assert property (
    wr_en_i[1] && ce_i |=> core_timer_o == $past(wr_data_i))
    else $error("core timer did not take the written value");
  a_core_wrap_value: assert property (
    wrap_o[1] |-> core_timer_o == 16'hffff || core_timer_o == 16'h0000)
    else $error("core wrap flagged away from a boundary value");
  a_second_stop_hold: assert property (
    !second_core_cfg_i.run && !wr_en_i[4] |=> $stable(second_core_timer_o))
    else $error("stopped second core timer changed");
  a_ce_freeze: assert property (
    !ce_i |=> $stable(core_timer_o) && $stable(core_toggle_latch_o))
    else $error("state moved while the clock enable was low");
  c_core_wrap: cover property (wrap_o[1]);
  c_second_wrap: cover property (compare_clk_o);
  c_reload_role: cover property (aux_a_cfg_i.role == `ROLE_RELOAD && $changed(core_timer_o));
endmodule
bind dual_group_timer_unit dgtu_checker #(.TW(TW)) u_chk (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .aux_a_cfg_i(aux_a_cfg_i),
  .second_core_cfg_i(second_core_cfg_i), .core_toggle_oe_en_i(core_toggle_oe_en_i),
  .second_toggle_oe_en_i(second_toggle_oe_en_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i),
  .aux_timer_a_o(aux_timer_a_o), .core_timer_o(core_timer_o),
  .second_core_timer_o(second_core_timer_o), .core_toggle_latch_o(core_toggle_latch_o),
  .second_toggle_latch_o(second_toggle_latch_o), .core_toggle_pin_o(core_toggle_pin_o),
  .second_toggle_pin_o(second_toggle_pin_o), .compare_clk_o(compare_clk_o), .wrap_o(wrap_o));

// >>> verification/pin_source_model.sv
// Behavioural source of the timer input, direction and capture pins.
`timescale 1ns/10ps
module pin_source_model (
  input wire logic mclk_i,
  output logic [2:0] tin_o,
  output logic [2:0] tdir_o,
  output logic cap_o
);
  // Pins rest low until a scenario moves them.
  initial begin
    tin_o = 3'h0;
    tdir_o = 3'h0;
    cap_o = 1'b0;
  end
  // Index 0 to 2 are timer inputs, 3 the capture pin, 4 to 6 direction pins.
  task automatic level(input int idx, input logic v);
    @(posedge mclk_i);
    if (idx < 3) begin
      tin_o[idx] <= v;
    end else if (idx == 3) begin
      cap_o <= v;
    end else begin
      tdir_o[idx-4] <= v;
    end
  endtask
  // An event is held two cycles high and two low so that both edges are clean.
  task automatic pulse(input int idx);
    level(idx, 1'b1);
    @(posedge mclk_i);
    level(idx, 1'b0);
    repeat (2) @(posedge mclk_i);
  endtask
endmodule

// >>> verification/dual_group_timer_unit_tb.sv
// Self-checking bench for the dual group timer unit.
`timescale 1ns/10ps
`include "timer_unit_defines.svh"
`define CHECK(a, e) begin \
  cmp_count++; \
  if ((a) !== (e)) begin \
    mismatches++; \
    $display("[FAIL] t=%0t got %h expected %h", $time, a, e); \
  end \
end
module dual_group_timer_unit_tb;
  import timer_unit_pkg::*;
  typedef struct {int sel; logic [15:0] val; int gap;} note_t;
  logic mclk_i, reset_n_i, cap_clr, latch1, latch2, pin1, pin2, cmp_clk, cap_pin, ce, oe1, oe2;
  grp1_cfg_t core_cfg, aux_a_cfg, aux_b_cfg;
  grp2_cfg_t s_core_cfg, s_aux_cfg;
  logic [1:0] cap_edge, cap_src, s_in, s_dir;
  logic [2:0] tin, tdir;
  logic [4:0] wr_en, wrap;
  logic [15:0] wr_data, lfsr_q, last_core, aux_a, core, aux_b, s_aux, s_core, capreg;
  note_t notes[$];
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  int last_cyc = 0;
  pin_source_model src (.mclk_i(mclk_i), .tin_o(tin), .tdir_o(tdir), .cap_o(cap_pin));
  dual_group_timer_unit #(.TW(16)) dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce), .core_cfg_i(core_cfg),
    .aux_a_cfg_i(aux_a_cfg), .aux_b_cfg_i(aux_b_cfg), .second_core_cfg_i(s_core_cfg),
    .second_aux_cfg_i(s_aux_cfg), .cap_edge_i(cap_edge), .cap_src_i(cap_src),
    .cap_clear_en_i(cap_clr), .core_toggle_oe_en_i(oe1), .second_toggle_oe_en_i(oe2),
    .timer_input_pin_i(tin), .direction_input_pin_i(tdir), .second_input_pin_i(s_in),
    .second_dir_pin_i(s_dir), .capture_input_pin_i(cap_pin), .wr_en_i(wr_en),
    .wr_data_i(wr_data), .aux_timer_a_o(aux_a), .core_timer_o(core), .aux_timer_b_o(aux_b),
    .second_aux_timer_o(s_aux), .second_core_timer_o(s_core), .capture_reload_reg_o(capreg),
    .core_toggle_latch_o(latch1), .second_toggle_latch_o(latch2), .core_toggle_pin_o(pin1),
    .second_toggle_pin_o(pin2), .compare_clk_o(cmp_clk), .wrap_o(wrap));
  // The clock toggles every 50 ns, half of a 100 ns period.
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] pick(input int sel);
    case (sel)
      1: return core;
      2: return aux_a;
      3: return aux_b;
      4: return capreg;
      5: return s_aux;
      6: return {12'h000, pin2, latch2, pin1, latch1};
      default: return s_core;
    endcase
  endfunction
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Waits until the watcher has taken every note, under a bounded count.
  task automatic drain();
    int k;
    k = 0;
    while (notes.size() > 0 && k < 3000) begin
      @(negedge mclk_i);
      k++;
    end
    if (k >= 3000) begin
      mismatches++;
      notes.delete();
    end
  endtask
  task automatic see(input int sel, input logic [15:0] val);
    notes.push_back('{sel, val, 0});
    drain();
  endtask
  task automatic wr(input int idx, input logic [15:0] val);
    @(posedge mclk_i);
    wr_en <= 5'h01 << idx;
    wr_data <= val;
    @(posedge mclk_i);
    wr_en <= 5'h00;
  endtask
  // Takes the oldest note: at once for a plain value, or on each new core value.
  always @(negedge mclk_i) begin
    if (notes.size() > 0 && notes[0].sel != 0) begin
      `CHECK(pick(notes[0].sel), notes[0].val)
      void'(notes.pop_front());
    end else if (core !== last_core) begin
      if (notes.size() > 0) begin
        `CHECK(core, notes[0].val)
        if (notes[0].gap != 0) `CHECK(cyc - last_cyc, notes[0].gap)
        void'(notes.pop_front());
      end
      last_core = core;
      last_cyc = cyc;
    end
  end
  // Counts cycles and cuts a hang short.
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  // Main sequence of scenarios.
  initial begin
    int s;
    int d;
    int n;
    logic lat;
    reset_n_i = 1'b0;
    {core_cfg, aux_a_cfg, aux_b_cfg, s_core_cfg, s_aux_cfg} = '0;
    {cap_edge, cap_src, cap_clr, wr_en, wr_data, s_in, s_dir} = '0;
    {ce, oe1, oe2} = 3'h7;
    last_core = 16'h0000;
    lfsr_q = 16'h002a;
    lat = 1'b0;
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    see(1, 16'h0000);
    see(6, 16'h0000);
    for (s = 0; s < 2; s++) begin
      for (d = 0; d < 2; d++) begin
        notes.push_back('{0, d ? 16'h0002 : 16'hfffd, 0});
        notes.push_back('{0, d ? 16'h0001 : 16'hfffe, 0});
        notes.push_back('{0, d ? 16'h0000 : 16'hffff, 4 << s});
        notes.push_back('{0, d ? 16'hffff : 16'h0000, 4 << s});
        wr(1, d ? 16'h0002 : 16'hfffd);
        @(posedge mclk_i);
        core_cfg <= '{run: 1'b1, prescale: 3'(s), soft_down: d[0], default: '0};
        drain();
        @(posedge mclk_i);
        core_cfg <= '0;
        oe1 <= s[0];
        lat = ~lat;
        see(6, {14'h0000, lat & s[0], lat});
      end
    end
    wr(1, 16'h0100);
    @(posedge mclk_i);
    core_cfg <= '{run: 1'b1, mode: `MODE_COUNTER, cnt_edge: `EDGE_RISE, ext_dir_en: 1'b1,
                  default: '0};
    lfsr_q = lfsr(lfsr_q);
    n = 1 + lfsr_q[2:0];
    repeat (n) src.pulse(1);
    src.level(5, 1'b1);
    repeat (2) src.pulse(1);
    see(1, 16'h00fe + 16'(n));
    src.level(5, 1'b0);
    wr(1, 16'h0000);
    @(posedge mclk_i);
    core_cfg <= '{run: 1'b1, mode: `MODE_GATED, default: '0};
    repeat (40) @(posedge mclk_i);
    see(1, 16'h0000);
    src.level(1, 1'b1);
    repeat (39) @(posedge mclk_i);
    src.level(1, 1'b0);
    see(1, 16'h000a);
    @(posedge mclk_i);
    core_cfg <= '0;
    // Clock enable low freezes the prescaler and the count.
    wr(1, 16'h0000);
    core_cfg <= '{run: 1'b1, default: '0};
    ce <= 1'b0;
    repeat (20) @(posedge mclk_i);
    ce <= 1'b1;
    repeat (4) @(posedge mclk_i);
    core_cfg <= '0;
    see(1, 16'h0001);
    lfsr_q = lfsr(lfsr_q);
    wr(0, lfsr_q);
    aux_a_cfg <= '{role: `ROLE_RELOAD, trig_edge: `EDGE_RISE, default: '0};
    src.pulse(0);
    see(1, lfsr_q);
    see(2, lfsr_q);
    @(posedge mclk_i);
    aux_a_cfg <= '0;
    lfsr_q = lfsr(lfsr_q);
    wr(1, lfsr_q);
    aux_b_cfg <= '{role: `ROLE_CAPTURE, trig_edge: `EDGE_RISE, default: '0};
    src.pulse(2);
    see(3, lfsr_q);
    lfsr_q = lfsr(lfsr_q);
    wr(3, lfsr_q);
    cap_edge <= `EDGE_RISE;
    cap_clr <= 1'b1;
    src.pulse(3);
    see(4, lfsr_q);
    see(5, 16'h0000);
    for (s = 1; s < 4; s++) begin
      @(posedge mclk_i);
      cap_clr <= 1'b0;
      cap_src <= 2'(s);
      lfsr_q = lfsr(lfsr_q);
      wr(3, lfsr_q);
      src.pulse(s == 2 ? 5 : 1);
      see(4, lfsr_q);
    end
    // Second aux counts rising edges of its own pin, downwards by its direction pin.
    @(posedge mclk_i);
    s_aux_cfg <= '{run: 1'b1, ext_clk: 1'b1, ext_dir_en: 1'b1, cnt_edge: `EDGE_RISE,
                   default: '0};
    s_dir <= 2'h1;
    repeat (3) begin
      @(posedge mclk_i);
      s_in <= 2'h1;
      repeat (2) @(posedge mclk_i);
      s_in <= 2'h0;
    end
    repeat (2) @(posedge mclk_i);
    s_aux_cfg <= '0;
    see(5, lfsr_q - 16'h0003);
    wr(4, 16'hfffe);
    s_core_cfg <= '{run: 1'b1, prescale: 3'h7, default: '0};
    n = 0;
    while (cmp_clk !== 1'b1 && n < 2000) begin
      @(negedge mclk_i);
      n++;
    end
    @(posedge mclk_i);
    s_core_cfg <= '0;
    see(7, lfsr_q);
    see(6, 16'h000c);
    @(posedge mclk_i);
    oe2 <= 1'b0;
    see(6, 16'h0004);
    end_sim();
  end
endmodule
